// *** shared/rss_params.svh ***
`ifndef RSS_PARAMS_SVH
`define RSS_PARAMS_SVH
// strap sampling delay after reset release, in ns
`define RSS_SAMPLE_DELAY_NS   1500
// system clock period, in ns
`define RSS_CLK_PERIOD_NS     100
// number of test strap pins
`define RSS_NUM_STRAPS        8
// bit of the strap bus that carries trigger output one
`define RSS_TRIG_PIN          4
// reset value of the latched strap word
`define RSS_STRAP_RST         8'h00
`endif

// *** shared/rss_pkg.sv ***
package rss_pkg;
   typedef enum logic [1:0] {
      RSS_HOLD   = 2'b00,
      RSS_WAIT   = 2'b01,
      RSS_SAMPLE = 2'b11,
      RSS_RUN    = 2'b10
   } rss_state_e;

   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
   } rss_pins_s;

   typedef struct packed {
      logic       config_start;
      logic       running;
      logic       test_mode;
      logic [7:0] strap_word;
   } rss_status_s;
endpackage

// *** src/rss_reset_strap_sampler.sv ***
// Contract
// RL1 - self-configuration starts only after a rising edge on power-on reset; the code also starts it on release of resetn alone.
// RL2 - all outputs stay inactive while power-on reset is held low.
// RL3 - all eight test pins are high impedance during reset.
// RL4 - about 1.5 us after release sample pins, then drive them.
// RL5 - after sampling, test pin four carries trigger output one.
// RL6 - pins rest low by pulldown, so open pins select normal operation.
// RL7 - outside logic must not pull test pins high at reset release.
// RL8 - reset stays asserted until all controller clocks are stable.
// RL9 - synchronise reset release and count clock cycles for sample delay.
`timescale 1ns/1ns
`include "rss_params.svh"
module rss_reset_strap_sampler #(
   parameter int NUM_STRAPS = `RSS_NUM_STRAPS,
   parameter int TRIG_PIN   = `RSS_TRIG_PIN
) (
   input  wire logic                power_on_reset_n,
   input  wire logic                ref_clk,
   input  wire logic                resetn,
   input  wire logic [7:0]          test_strap_pin_in,
   input  wire logic [7:0]          test_out_data,
   input  wire logic                trigger_output_one,
   output rss_pkg::rss_pins_s       test_strap_pin,
   output rss_pkg::rss_status_s     status
);
   import rss_pkg::*;

   localparam int DELAY_CYC_RAW = `RSS_SAMPLE_DELAY_NS / `RSS_CLK_PERIOD_NS;
   localparam int DELAY_CYC     = (DELAY_CYC_RAW < 1) ? 1 : DELAY_CYC_RAW;
   localparam int CW            = $clog2(DELAY_CYC + 1);

   initial begin
      if (NUM_STRAPS != 8 || TRIG_PIN < 0 || TRIG_PIN >= NUM_STRAPS) begin
         $error("rss: unsupported strap configuration");
      end
   end

   // both resets hold the block; their release is synchronised
   logic       arst_n;
   logic       por_meta_r;
   logic       por_sync_r;
   logic [7:0] pin_meta_r;
   logic [7:0] pin_sync_r;

   assign arst_n = resetn & power_on_reset_n;

   // RL9 release synchroniser
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         por_meta_r <= 1'b0;
         por_sync_r <= 1'b0;
      end else begin
         por_meta_r <= 1'b1;
         por_sync_r <= por_meta_r;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_meta_r <= `RSS_STRAP_RST;
         pin_sync_r <= `RSS_STRAP_RST;
      end else begin
         pin_meta_r <= test_strap_pin_in;
         pin_sync_r <= pin_meta_r;
      end
   end

   rss_state_e    state_r;
   rss_state_e    state_nxt;
   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;
   logic [7:0]    strap_r;
   logic [7:0]    strap_nxt;

   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      strap_nxt = strap_r;
      unique case (state_r)
         RSS_HOLD: begin
            // RL1 start on release edge
            if (por_sync_r) begin
               state_nxt = RSS_WAIT;
               cnt_nxt   = '0;
            end
         end
         RSS_WAIT: begin
            // RL4 count sample delay
            if (cnt_r == CW'(DELAY_CYC - 1)) begin
               state_nxt = RSS_SAMPLE;
            end else begin
               cnt_nxt = cnt_r + CW'(1);
            end
         end
         RSS_SAMPLE: begin
            // RL6 low reads mean normal mode
            strap_nxt = pin_sync_r;
            state_nxt = RSS_RUN;
         end
         RSS_RUN: begin
            state_nxt = RSS_RUN;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= RSS_HOLD;
         cnt_r   <= '0;
         strap_r <= `RSS_STRAP_RST;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         strap_r <= strap_nxt;
      end
   end

   rss_pins_s   pins_nxt;
   rss_status_s stat_nxt;

   always_comb begin
      pins_nxt = '0;
      stat_nxt = '0;
      // RL3 pins undriven until run
      if (state_nxt == RSS_RUN) begin
         pins_nxt.oe  = 8'hFF;
         pins_nxt.out = test_out_data;
         // RL5 trigger on pin four
         pins_nxt.out[TRIG_PIN] = trigger_output_one;
         stat_nxt.running       = 1'b1;
      end
      stat_nxt.config_start = (state_nxt != RSS_HOLD);
      stat_nxt.strap_word   = strap_nxt;
      stat_nxt.test_mode    = |strap_nxt;
   end

   // RL2 outputs inactive in reset
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         test_strap_pin <= '0;
         status         <= '0;
      end else begin
         test_strap_pin <= pins_nxt;
         status         <= stat_nxt;
      end
   end
endmodule

// *** verification/rss_por_model.sv ***
`timescale 1ns/1ns
module rss_por_model (
   input wire logic ref_clk,
   input wire logic rel,
   output logic power_on_reset_n
);
   always @(posedge ref_clk) power_on_reset_n <= rel;
endmodule

// *** verification/rss_reset_strap_sampler_tb.sv ***
`timescale 1ns/1ns
module rss_reset_strap_sampler_tb;
   logic ref_clk = 0, resetn = 0, rel = 0, trigger_output_one = 0, power_on_reset_n;
   logic [7:0] test_strap_pin_in = 0, test_out_data = 0;
   rss_pkg::rss_pins_s test_strap_pin;
   rss_pkg::rss_status_s status;
   int num_errors, tests_run;
   // second row pulls pin four high
   logic [16:0] rows [2] = '{{8'h00, 8'hA5, 1'h1}, {8'h10, 8'h5A, 1'h0}};
   rss_por_model u_por (.*);
   rss_reset_strap_sampler u_dut (.*);
   task chk(string n, logic [15:0] e, g);
      tests_run++;
      if (g !== e) begin
         $display("unexpected %s %h %h", n, e, g);
         num_errors++;
      end
   endtask
   task stop_test;
      $display("errors %0d tests %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial forever #50 ref_clk = ~ref_clk;
   initial #20_000 begin
      num_errors++;
      stop_test;
   end
   initial begin
      repeat (6) @(negedge ref_clk);
      resetn = 1;
      foreach (rows[k]) begin
         {test_strap_pin_in, test_out_data, trigger_output_one} = rows[k];
         rel = 0;
         repeat (3) @(negedge ref_clk);
         rel = 1;
         repeat (30) if (!status.running) @(negedge ref_clk);
         chk("run", {test_strap_pin_in, 8'hFF}, {status.strap_word, test_strap_pin.oe});
         chk("out", {8'h00, test_out_data[7:5], trigger_output_one, test_out_data[3:0]},
             {8'h00, test_strap_pin.out});
         chk("mode", 16'(|test_strap_pin_in), 16'(status.test_mode));
         trigger_output_one = ~trigger_output_one;
         @(negedge ref_clk);
         chk("trig", 16'(!rows[k][0]), 16'(test_strap_pin.out[4]));
         repeat (2) @(negedge ref_clk);
      end
      // power-on reset dropped in mid-run
      rel = 0;
      repeat (2) @(negedge ref_clk);
      chk("por hold", 16'h0000, {test_strap_pin.oe, 7'h00, status.config_start});
      rel = 1;
      repeat (2) @(negedge ref_clk);
      chk("early", 16'h0000, 16'(status.config_start));
      repeat (30) if (!status.running) @(negedge ref_clk);
      chk("rerun", 16'h00FF, {8'h00, test_strap_pin.oe});
      // system reset dropped in mid-run
      resetn = 0;
      @(negedge ref_clk);
      chk("rst hold", 16'h0000, {test_strap_pin.oe, 7'h00, status.running});
      resetn = 1;
      repeat (30) if (!status.running) @(negedge ref_clk);
      chk("rst rerun", 16'h00FF, {8'h00, test_strap_pin.oe});
      stop_test;
   end
endmodule

// *** verification/rss_sva.sv ***
`timescale 1ns/1ns
module rss_sva (
   input wire logic power_on_reset_n, ref_clk, resetn, trigger_output_one,
   input wire logic [7:0] test_out_data,
   input rss_pkg::rss_pins_s test_strap_pin,
   input rss_pkg::rss_status_s status
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn || !power_on_reset_n);
   sequence s_on; status.running && $past(status.running); endsequence
   hold_quiet_a: assert property (disable iff (!resetn) !power_on_reset_n |->
      {test_strap_pin, status} == 0) else $error("active in reset");
   start_gate_a: assert property ($rose(status.config_start) |->
      $past(power_on_reset_n, 2)) else $error("early start");
   sample_time_a: assert property ($rose(status.running) |->
      $past(status.config_start, 15) && !$past(status.config_start, 18)) else $error("delay");
   trig_pin_a: assert property (s_on |-> test_strap_pin.out ==
      $past({test_out_data[7:5], trigger_output_one, test_out_data[3:0]})) else $error("out");
   test_mode_a: assert property (status.test_mode == |status.strap_word) else $error("mode");
   pin_enable_a: assert property (status.running == (test_strap_pin.oe == 8'hFF))
      else $error("pin enable");
endmodule
bind rss_reset_strap_sampler rss_sva u_sva (.*);
